// >>> src/dvzgb_top.sv
// register bank for z delta velocity and x/y gyroscope bias with the bias adders
// assumes the serial front end delivers byte writes and word reads on sys_clk
//
// Overview of operation
// - z velocity-change low word is read-only and holds the extra resolution bits
// - z velocity-change main word is read-only twos complement, zero reads 0x0000
// - main word is the upper half, low word the lower half of 32 bits
// - 16-bit form: 0x7FFF top, 0x8000 minus full scale, 0xFFFF minus one
// - 32-bit form: 0x80000000 minus full scale, 0xFFFFFFFF minus one LSB
// - correction processing updates at 2000 Hz from the internal sample clock
// - factory coefficients stay hidden; only per-sensor bias is user adjustable
// - x gyro bias lower word is read/write, resets to zero, flash backed
// - x gyro bias upper word is read/write, resets to zero, flash backed
// - y gyro bias lower and upper words behave like the x pair
// - each axis joins its lower and upper bias words into one 32-bit correction
// - delta velocity is trapezoidal integration over one decimation period
module dvzgb_top
	import dvzgb_pkg::*;
#(
	parameter int UPDATE_CYCLES_P = UPDATE_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic reg_wr_en,
	input wire logic [ADDR_W-1:0] reg_wr_addr,
	input wire logic [BYTE_W-1:0] reg_wr_data,
	input wire logic reg_rd_en,
	input wire logic [ADDR_W-1:0] reg_rd_addr,
	output logic [WORD_W-1:0] reg_rd_data,
	output logic reg_rd_valid,
	input wire logic [DATA_W-1:0] accel_z,
	input wire logic [DATA_W-1:0] gyro_x_rate,
	input wire logic [DATA_W-1:0] gyro_y_rate,
	input wire logic [WORD_W-1:0] decimation_setting,
	input wire logic bias_restore,
	input wire logic [DATA_W-1:0] bias_restore_x,
	input wire logic [DATA_W-1:0] bias_restore_y,
	output logic sample_tick,
	output logic [DATA_W-1:0] gyro_x_corrected,
	output logic [DATA_W-1:0] gyro_y_corrected,
	output logic gyro_corrected_valid,
	output logic [DATA_W-1:0] bias_x_word,
	output logic [DATA_W-1:0] bias_y_word,
	output logic dv_z_update
);
	logic [TICK_W-1:0] tick_cnt;
	logic [DATA_W-1:0] dv_value;
	logic dv_update;
	logic [WORD_W-1:0] z_velocity_change_low;
	logic [WORD_W-1:0] z_velocity_change_main;
	logic [WORD_W-1:0] rate_offset_lower [0:AXES-1];
	logic [WORD_W-1:0] rate_offset_upper [0:AXES-1];
	logic [DATA_W-1:0] bias_word [0:AXES-1];
	logic [DATA_W-1:0] rate_in [0:AXES-1];
	logic [DATA_W-1:0] restore_in [0:AXES-1];
	logic [DATA_W-1:0] rate_out [0:AXES-1];
	logic [WORD_W-1:0] next_rd_data;

	assign rate_in[0] = gyro_x_rate;
	assign rate_in[1] = gyro_y_rate;
	assign restore_in[0] = bias_restore_x;
	assign restore_in[1] = bias_restore_y;
	assign gyro_x_corrected = rate_out[0];
	assign gyro_y_corrected = rate_out[1];
	assign bias_x_word = bias_word[0];
	assign bias_y_word = bias_word[1];
	assign dv_z_update = dv_update;

	// sample clock divider
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tick_cnt <= '0;
			sample_tick <= 1'b0;
		end else if (tick_cnt == TICK_W'(UPDATE_CYCLES_P - 1)) begin
			tick_cnt <= '0;
			sample_tick <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 16'h0001;
			sample_tick <= 1'b0;
		end
	end

	dvzgb_integ u_integ (
		.sys_clk(sys_clk),
		.rst(rst),
		.sample_en(sample_tick),
		.accel(accel_z),
		.decimation_setting(decimation_setting),
		.dv_value(dv_value),
		.dv_update(dv_update)
	);

	// both halves latched together so a 16- or 32-bit read is coherent
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			z_velocity_change_low <= READ_ZERO;
			z_velocity_change_main <= READ_ZERO;
		end else if (dv_update) begin
			z_velocity_change_main <= dv_value[DATA_W-1:WORD_W];
			z_velocity_change_low <= dv_value[WORD_W-1:0];
		end
	end

	generate
		for (genvar g = 0; g < AXES; g++) begin : g_axis
			localparam logic [ADDR_W-1:0] LO_A = ADDR_X_RATE_LO + 7'(g) * BIAS_STRIDE;
			localparam logic [ADDR_W-1:0] HI_A = LO_A + HI_OFFSET;
			logic hit_lo;
			logic hit_hi;
			logic signed [ACC_W-1:0] sum;

			assign hit_lo = reg_wr_en && reg_wr_addr[ADDR_W-1:1] == LO_A[ADDR_W-1:1];
			assign hit_hi = reg_wr_en && reg_wr_addr[ADDR_W-1:1] == HI_A[ADDR_W-1:1];

			// restore from backup wins over a write in the same cycle
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					rate_offset_lower[g] <= BIAS_RESET;
				end else if (bias_restore) begin
					rate_offset_lower[g] <= restore_in[g][WORD_W-1:0];
				end else if (hit_lo && reg_wr_addr[0] == BYTE_SEL_LOW) begin
					rate_offset_lower[g][BYTE_W-1:0] <= reg_wr_data;
				end else if (hit_lo) begin
					rate_offset_lower[g][WORD_W-1:BYTE_W] <= reg_wr_data;
				end
			end

			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					rate_offset_upper[g] <= BIAS_RESET;
				end else if (bias_restore) begin
					rate_offset_upper[g] <= restore_in[g][DATA_W-1:WORD_W];
				end else if (hit_hi && reg_wr_addr[0] == BYTE_SEL_LOW) begin
					rate_offset_upper[g][BYTE_W-1:0] <= reg_wr_data;
				end else if (hit_hi) begin
					rate_offset_upper[g][WORD_W-1:BYTE_W] <= reg_wr_data;
				end
			end

			// upper word aligns with the 16-bit rate, the pair with the 32-bit rate
			assign bias_word[g] = {rate_offset_upper[g], rate_offset_lower[g]};
			assign sum = ACC_W'(signed'(rate_in[g])) + ACC_W'(signed'(bias_word[g]));

			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					rate_out[g] <= DV_RESET;
				end else if (sample_tick) begin
					rate_out[g] <= dvzgb_sat32(sum);
				end
			end
		end
	endgenerate

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			gyro_corrected_valid <= 1'b0;
		end else begin
			gyro_corrected_valid <= sample_tick;
		end
	end

	// read decode; anything else in the map reads zero
	always_comb begin
		next_rd_data = READ_ZERO;
		case (reg_rd_addr[ADDR_W-1:1])
			ADDR_Z_VEL_LOW[ADDR_W-1:1]: next_rd_data = z_velocity_change_low;
			ADDR_Z_VEL_MAIN[ADDR_W-1:1]: next_rd_data = z_velocity_change_main;
			ADDR_X_RATE_LO[ADDR_W-1:1]: next_rd_data = rate_offset_lower[0];
			ADDR_X_RATE_HI[ADDR_W-1:1]: next_rd_data = rate_offset_upper[0];
			ADDR_Y_RATE_LO[ADDR_W-1:1]: next_rd_data = rate_offset_lower[1];
			ADDR_Y_RATE_HI[ADDR_W-1:1]: next_rd_data = rate_offset_upper[1];
			default: next_rd_data = READ_ZERO;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			reg_rd_data <= READ_ZERO;
			reg_rd_valid <= 1'b0;
		end else begin
			reg_rd_valid <= reg_rd_en;
			if (reg_rd_en) begin
				reg_rd_data <= next_rd_data;
			end
		end
	end

	// checking helpers
	logic [TICK_W-1:0] gap_cnt;
	logic tick_seen;
	logic rd_unmapped;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			gap_cnt <= '0;
			tick_seen <= 1'b0;
		end else if (sample_tick) begin
			gap_cnt <= '0;
			tick_seen <= 1'b1;
		end else begin
			gap_cnt <= gap_cnt + 16'h0001;
		end
	end

	assign rd_unmapped = reg_rd_addr[ADDR_W-1:1] != ADDR_Z_VEL_LOW[ADDR_W-1:1]
		&& reg_rd_addr[ADDR_W-1:1] != ADDR_Z_VEL_MAIN[ADDR_W-1:1]
		&& reg_rd_addr[ADDR_W-1:1] != ADDR_X_RATE_LO[ADDR_W-1:1]
		&& reg_rd_addr[ADDR_W-1:1] != ADDR_X_RATE_HI[ADDR_W-1:1]
		&& reg_rd_addr[ADDR_W-1:1] != ADDR_Y_RATE_LO[ADDR_W-1:1]
		&& reg_rd_addr[ADDR_W-1:1] != ADDR_Y_RATE_HI[ADDR_W-1:1];

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	sequence s_main_read;
		reg_rd_en && reg_rd_addr[ADDR_W-1:1] == ADDR_Z_VEL_MAIN[ADDR_W-1:1];
	endsequence

	sequence s_low_read;
		reg_rd_en && reg_rd_addr[ADDR_W-1:1] == ADDR_Z_VEL_LOW[ADDR_W-1:1];
	endsequence

	sequence s_x_lo_byte_write;
		reg_wr_en && !bias_restore && reg_wr_addr == ADDR_X_RATE_LO;
	endsequence

	property p_tick_spacing;
		sample_tick && tick_seen |-> gap_cnt == TICK_W'(UPDATE_CYCLES_P - 1);
	endproperty
	a_tick_spacing: assert property (p_tick_spacing) else $error("sample tick spacing wrong");

	property p_dv_capture;
		dv_update |=> {z_velocity_change_main, z_velocity_change_low} == $past(dv_value);
	endproperty
	a_dv_capture: assert property (p_dv_capture) else $error("delta velocity not captured");

	property p_main_read;
		s_main_read ##0 !dv_update |=> reg_rd_valid && reg_rd_data == z_velocity_change_main;
	endproperty
	a_main_read: assert property (p_main_read) else $error("main word read wrong");

	property p_low_read;
		s_low_read ##0 !dv_update |=> reg_rd_valid && reg_rd_data == z_velocity_change_low;
	endproperty
	a_low_read: assert property (p_low_read) else $error("low word read wrong");

	property p_unmapped_zero;
		reg_rd_en && rd_unmapped |=> reg_rd_valid && reg_rd_data == READ_ZERO;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

	property p_x_lo_write;
		s_x_lo_byte_write |=> rate_offset_lower[0][BYTE_W-1:0] == $past(reg_wr_data)
			&& rate_offset_lower[0][WORD_W-1:BYTE_W] == $past(rate_offset_lower[0][WORD_W-1:BYTE_W]);
	endproperty
	a_x_lo_write: assert property (p_x_lo_write) else $error("x bias lower byte write wrong");

	property p_bias_reset;
		$fell(rst) && !bias_restore && !reg_wr_en |=> bias_word[0] == DV_RESET && bias_word[1] == DV_RESET;
	endproperty
	a_bias_reset: assert property (p_bias_reset) else $error("bias words not zero after reset");

	property p_y_restore;
		bias_restore |=> bias_word[1] == $past(bias_restore_y) && bias_word[0] == $past(bias_restore_x);
	endproperty
	a_y_restore: assert property (p_y_restore) else $error("bias restore not applied");

	property p_x_correct;
		sample_tick |=> rate_out[0] == dvzgb_sat32(ACC_W'(signed'($past(gyro_x_rate)))
			+ ACC_W'(signed'($past(bias_word[0])))) ##1 gyro_corrected_valid == 1'b0;
	endproperty
	a_x_correct: assert property (p_x_correct) else $error("x rate correction wrong");

	property p_dv_on_tick;
		dv_update |-> $past(sample_tick);
	endproperty
	a_dv_on_tick: assert property (p_dv_on_tick) else $error("delta velocity update off tick");

	property p_dv_min;
		sample_tick && u_integ.state == DVZGB_RUN && u_integ.close_period
			&& (u_integ.next_acc >>> DV_SHIFT) < SAT_LO |=> dv_update && dv_value == DATA_MIN;
	endproperty
	a_dv_min: assert property (p_dv_min) else $error("delta velocity below minus full scale");
endmodule : dvzgb_top

// >>> src/dvzgb_pkg.sv
// constants, register map and helpers for the z delta-velocity and gyro bias bank
// assumes a 50 MHz system clock and byte-wide register writes from the serial front end
package dvzgb_pkg;
	localparam int ADDR_W = 7;
	localparam int WORD_W = 16;
	localparam int BYTE_W = 8;
	localparam int DATA_W = 32;
	localparam int ACC_W = 48;
	localparam int AXES = 2;
	localparam int TICK_W = 16;

	localparam logic [ADDR_W-1:0] ADDR_Z_VEL_LOW = 7'h38;
	localparam logic [ADDR_W-1:0] ADDR_Z_VEL_MAIN = 7'h3A;
	localparam logic [ADDR_W-1:0] ADDR_X_RATE_LO = 7'h40;
	localparam logic [ADDR_W-1:0] ADDR_X_RATE_HI = 7'h42;
	localparam logic [ADDR_W-1:0] ADDR_Y_RATE_LO = 7'h44;
	localparam logic [ADDR_W-1:0] ADDR_Y_RATE_HI = 7'h46;
	localparam logic [ADDR_W-1:0] BIAS_STRIDE = 7'h04;
	localparam logic [ADDR_W-1:0] HI_OFFSET = 7'h02;
	localparam logic BYTE_SEL_LOW = 1'b0;

	localparam logic [WORD_W-1:0] BIAS_RESET = 16'h0000;
	localparam logic [WORD_W-1:0] READ_ZERO = 16'h0000;
	localparam logic [DATA_W-1:0] DV_RESET = 32'h00000000;
	localparam logic [DATA_W-1:0] DATA_MAX = 32'h7FFFFFFF;
	localparam logic [DATA_W-1:0] DATA_MIN = 32'h80000000;
	localparam logic signed [ACC_W-1:0] SAT_HI = 48'sh00007FFFFFFF;
	localparam logic signed [ACC_W-1:0] SAT_LO = 48'shFFFF80000000;
	localparam logic signed [ACC_W-1:0] ACC_ZERO = 48'sh000000000000;
	localparam int DV_SHIFT = 1;

	localparam int SYS_CLK_HZ = 50000000;
	localparam int UPDATE_RATE_HZ = 2000;
	localparam int UPDATE_CYCLES = SYS_CLK_HZ / UPDATE_RATE_HZ;

	typedef enum logic [1:0] {
		DVZGB_PRIME = 2'b00,
		DVZGB_RUN = 2'b01
	} dvzgb_state_t;

	function automatic logic [DATA_W-1:0] dvzgb_sat32(input logic signed [ACC_W-1:0] v);
		logic [DATA_W-1:0] r;
		r = v[DATA_W-1:0];
		if (v > SAT_HI) begin
			r = DATA_MAX;
		end else if (v < SAT_LO) begin
			r = DATA_MIN;
		end
		return r;
	endfunction : dvzgb_sat32
endpackage : dvzgb_pkg

// >>> src/dvzgb_integ.sv
// trapezoidal integrator producing one z delta-velocity word per decimation period
// assumes sample_en pulses once per internal sample and accel is valid in that cycle
module dvzgb_integ
	import dvzgb_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic sample_en,
	input wire logic [DATA_W-1:0] accel,
	input wire logic [WORD_W-1:0] decimation_setting,
	output logic [DATA_W-1:0] dv_value,
	output logic dv_update
);
	dvzgb_state_t state;
	logic signed [ACC_W-1:0] acc;
	logic signed [ACC_W-1:0] next_acc;
	logic signed [DATA_W-1:0] prev;
	logic [WORD_W-1:0] count;
	logic close_period;

	// sum of the current and previous sample over the period
	assign next_acc = acc + ACC_W'(signed'(accel)) + ACC_W'(prev);
	assign close_period = (count >= decimation_setting);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state <= DVZGB_PRIME;
		end else if (sample_en) begin
			case (state)
				DVZGB_PRIME: state <= DVZGB_RUN;
				DVZGB_RUN: state <= DVZGB_RUN;
				default: state <= DVZGB_PRIME;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			prev <= '0;
		end else if (sample_en) begin
			prev <= signed'(accel);
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			acc <= ACC_ZERO;
			count <= '0;
		end else if (sample_en && state == DVZGB_RUN) begin
			if (close_period) begin
				acc <= ACC_ZERO;
				count <= '0;
			end else begin
				acc <= next_acc;
				count <= count + 16'h0001;
			end
		end
	end

	// halving folds in the 1/2 of the trapezoid; saturation keeps both encodings legal
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			dv_value <= DV_RESET;
			dv_update <= 1'b0;
		end else begin
			dv_update <= 1'b0;
			if (sample_en && state == DVZGB_RUN && close_period) begin
				dv_value <= dvzgb_sat32(next_acc >>> DV_SHIFT);
				dv_update <= 1'b1;
			end
		end
	end
endmodule : dvzgb_integ

// >>> dv/dvzgb_host.sv
// host model: byte writes and word reads on the register port
// assumes sys_clk from the bench and the one-cycle read answer of the bank
module dvzgb_host
	import dvzgb_pkg::*;
(
	input wire logic sys_clk,
	output logic reg_wr_en,
	output logic [ADDR_W-1:0] reg_wr_addr,
	output logic [BYTE_W-1:0] reg_wr_data,
	output logic reg_rd_en,
	output logic [ADDR_W-1:0] reg_rd_addr,
	input wire logic [WORD_W-1:0] reg_rd_data,
	input wire logic reg_rd_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		reg_wr_en = 1'b0;
		reg_wr_addr = 7'h00;
		reg_wr_data = 8'h00;
		reg_rd_en = 1'b0;
		reg_rd_addr = 7'h00;
	end
	// low byte then high byte, back to back
	task automatic wr_word(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
		@(posedge sys_clk);
		#1;
		reg_wr_en = 1'b1;
		reg_wr_addr = a;
		reg_wr_data = d[7:0];
		@(posedge sys_clk);
		#1;
		reg_wr_addr = a | 7'h01;
		reg_wr_data = d[15:8];
		@(posedge sys_clk);
		#1;
		reg_wr_en = 1'b0;
		reg_wr_addr = ~reg_wr_addr;
		reg_wr_data = ~reg_wr_data;
	endtask : wr_word
	// answer taken at the edge after the request
	task automatic rd_word(input logic [ADDR_W-1:0] a, output logic [WORD_W-1:0] d, output logic ok);
		@(posedge sys_clk);
		#1;
		reg_rd_en = 1'b1;
		reg_rd_addr = a;
		@(posedge sys_clk);
		#1;
		ok = reg_rd_valid;
		d = reg_rd_data;
		reg_rd_en = 1'b0;
		reg_rd_addr = ~a;
	endtask : rd_word
	// main word is the upper half, low word the lower half
	task automatic rd_dv32(output logic [DATA_W-1:0] v, output logic ok);
		logic [WORD_W-1:0] hi;
		logic [WORD_W-1:0] lo;
		logic ok2;
		rd_word(ADDR_Z_VEL_MAIN, hi, ok);
		rd_word(ADDR_Z_VEL_LOW, lo, ok2);
		v = {hi, lo};
		ok = ok & ok2;
	endtask : rd_dv32
endmodule : dvzgb_host

// >>> dv/dvzgb_top_test.sv
// self-checking bench for the z delta-velocity and gyro bias bank
// assumes a short update period parameter and the host model on the register port
module dvzgb_top_test;
	import dvzgb_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PER = 10;
	logic sys_clk, rst, reg_wr_en, reg_rd_en, reg_rd_valid, bias_restore;
	logic [ADDR_W-1:0] reg_wr_addr, reg_rd_addr;
	logic [BYTE_W-1:0] reg_wr_data;
	logic [WORD_W-1:0] reg_rd_data, decimation_setting;
	logic [DATA_W-1:0] accel_z, gyro_x_rate, gyro_y_rate, bias_restore_x, bias_restore_y;
	logic sample_tick, gyro_corrected_valid, dv_z_update;
	logic [DATA_W-1:0] gyro_x_corrected, gyro_y_corrected, bias_x_word, bias_y_word;
	int err_count = 0;
	int check_count = 0;
	dvzgb_top #(.UPDATE_CYCLES_P(PER)) u_dvzgb_top (.sys_clk(sys_clk), .rst(rst), .reg_wr_en(reg_wr_en),
		.reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_addr(reg_rd_addr),
		.reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .accel_z(accel_z), .gyro_x_rate(gyro_x_rate),
		.gyro_y_rate(gyro_y_rate), .decimation_setting(decimation_setting), .bias_restore(bias_restore),
		.bias_restore_x(bias_restore_x), .bias_restore_y(bias_restore_y), .sample_tick(sample_tick),
		.gyro_x_corrected(gyro_x_corrected), .gyro_y_corrected(gyro_y_corrected),
		.gyro_corrected_valid(gyro_corrected_valid), .bias_x_word(bias_x_word), .bias_y_word(bias_y_word),
		.dv_z_update(dv_z_update));
	dvzgb_host u_dvzgb_host (.sys_clk(sys_clk), .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
		.reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data),
		.reg_rd_valid(reg_rd_valid));
	always #10 sys_clk = ~sys_clk;
	task automatic conclude;
		if (err_count == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : conclude
	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] exp);
		logic [WORD_W-1:0] d;
		logic ok;
		u_dvzgb_host.rd_word(a, d, ok);
		chk({31'h0, ok}, 32'h1);
		chk({16'h0, d}, {16'h0, exp});
	endtask : rdchk
	// waits n pulses of the update flag or the corrected flag
	task automatic wait_flag(input bit dv, input int n);
		int k;
		for (int i = 0; i < n; i++) begin
			k = 0;
			do begin
				@(posedge sys_clk);
				#1;
				k++;
			end while ((dv ? dv_z_update : gyro_corrected_valid) !== 1'b1 && k < 200);
			chk({31'h0, dv ? dv_z_update : gyro_corrected_valid}, 32'h1);
		end
	endtask : wait_flag
	task automatic t_reset;
		logic [ADDR_W-1:0] a [6] = '{7'h38, 7'h3A, 7'h40, 7'h42, 7'h44, 7'h46};
		foreach (a[i]) rdchk(a[i], 16'h0000);
		chk(bias_x_word, 32'h00000000);
		chk(bias_y_word, 32'h00000000);
	endtask : t_reset
	task automatic t_regs;
		u_dvzgb_host.wr_word(7'h40, 16'hA5C3);
		u_dvzgb_host.wr_word(7'h42, 16'h8001);
		u_dvzgb_host.wr_word(7'h44, 16'h00FF);
		u_dvzgb_host.wr_word(7'h46, 16'hFFFE);
		u_dvzgb_host.wr_word(7'h3A, 16'h1234);
		u_dvzgb_host.wr_word(7'h50, 16'h5555);
		rdchk(7'h40, 16'hA5C3);
		rdchk(7'h42, 16'h8001);
		rdchk(7'h44, 16'h00FF);
		rdchk(7'h46, 16'hFFFE);
		rdchk(7'h3A, 16'h0000);
		rdchk(7'h50, 16'h0000);
		chk(bias_x_word, 32'h8001A5C3);
		chk(bias_y_word, 32'hFFFE00FF);
	endtask : t_regs
	task automatic t_bias;
		gyro_x_rate = 32'h7FFE5A3D;
		gyro_y_rate = 32'h80000000;
		wait_flag(1'b0, 2);
		chk(gyro_x_corrected, 32'h00000000);
		chk(gyro_y_corrected, 32'h80000000);
	endtask : t_bias
	task automatic t_tick;
		int k;
		k = 0;
		@(posedge sample_tick);
		do begin
			@(posedge sys_clk);
			#1;
			k++;
		end while (sample_tick !== 1'b1 && k < 100);
		chk(k, PER);
	endtask : t_tick
	task automatic t_dv;
		logic [DATA_W-1:0] a [4] = '{32'h7FFFFFFF, 32'h80000000, 32'hFFFFFFFF, 32'hFFFFFFFE};
		logic [DATA_W-1:0] v;
		logic ok;
		foreach (a[i]) begin
			accel_z = a[i];
			wait_flag(1'b1, 2);
			u_dvzgb_host.rd_dv32(v, ok);
			chk({31'h0, ok}, 32'h1);
			chk(v, a[i]);
		end
		decimation_setting = 16'h0002;
		accel_z = 32'h00000004;
		wait_flag(1'b1, 3);
		u_dvzgb_host.rd_dv32(v, ok);
		chk(v, 32'h0000000C);
		decimation_setting = 16'h0001;
		accel_z = 32'h80000000;
		wait_flag(1'b1, 3);
		u_dvzgb_host.rd_dv32(v, ok);
		chk({31'h0, ok}, 32'h1);
		chk(v, 32'h80000000);
	endtask : t_dv
	task automatic t_restore;
		bias_restore_x = 32'h12345678;
		bias_restore_y = 32'h9ABCDEF0;
		bias_restore = 1'b1;
		@(posedge sys_clk);
		#1;
		bias_restore = 1'b0;
		chk(bias_x_word, 32'h12345678);
		chk(bias_y_word, 32'h9ABCDEF0);
		rdchk(7'h42, 16'h1234);
		rdchk(7'h44, 16'hDEF0);
	endtask : t_restore
	initial begin
		sys_clk = 1'b0;
		rst = 1'b1;
		accel_z = 32'h00000000;
		gyro_x_rate = 32'h00000000;
		gyro_y_rate = 32'h00000000;
		decimation_setting = 16'h0000;
		bias_restore = 1'b0;
		bias_restore_x = 32'h00000000;
		bias_restore_y = 32'h00000000;
		repeat (10) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		t_reset();
		t_regs();
		t_bias();
		t_tick();
		t_dv();
		t_restore();
		conclude();
	end
	// guards against a hang
	initial begin
		#200000;
		err_count++;
		conclude();
	end
endmodule : dvzgb_top_test
